// >>> design/udi_pkg.sv
// constants, field layouts, carrier types and state codes of the serial channel
package udi_pkg;

  // register byte offsets
  localparam logic [5:0] OFF_MODE  = 6'h00;
  localparam logic [5:0] OFF_CTRL0 = 6'h04;
  localparam logic [5:0] OFF_CTRL1 = 6'h08;
  localparam logic [5:0] OFF_TXBUF = 6'h0C;
  localparam logic [5:0] OFF_RXBUF = 6'h10;
  localparam logic [5:0] OFF_BRG   = 6'h14;

  // channel mode register fields
  localparam int MODE_STOP2    = 0;
  localparam int MODE_PAR_ODD  = 1;
  localparam int MODE_PAR_EN   = 2;
  localparam int MODE_LINE_INV = 3;
  // first channel control register fields
  localparam int CTRL0_EDGE    = 0;
  localparam int CTRL0_ORDER   = 1;
  localparam int CTRL0_TX_BUSY = 2;
  // second channel control register fields
  localparam int CTRL1_TX_EN    = 0;
  localparam int CTRL1_TX_EMPTY = 1;
  localparam int CTRL1_RX_EN    = 2;
  localparam int CTRL1_RX_FULL  = 3;
  localparam int CTRL1_DATA_INV = 4;
  // receive buffer register flags
  localparam int RXBUF_OVERRUN = 12;
  localparam int RXBUF_FRAMING = 13;
  localparam int RXBUF_PARITY  = 14;
  localparam int RXBUF_FULL    = 15;

  // reset values
  localparam logic [15:0] BRG_RESET  = 16'h0000;
  localparam logic [7:0]  DATA_RESET = 8'h00;

  // sixteen divider ticks make one bit time
  localparam logic [3:0] PHASE_FALL   = 4'hF;
  localparam logic [3:0] PHASE_RISE   = 4'h7;
  localparam logic [3:0] PHASE_SAMPLE = 4'h7;
  localparam logic [3:0] DATA_BITS    = 4'h8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef struct packed {
    logic lineInvert;
    logic parityEnable;
    logic parityOdd;
    logic stopBitCount;
  } udi_mode_t;

  typedef struct packed {
    logic dataInvert;
    logic rxEnable;
    logic txEnable;
    logic bitOrder;
    logic clockEdge;
  } udi_ctrl_t;

  typedef enum logic [4:0] {
    TX_IDLE   = 5'b00001,
    TX_START  = 5'b00010,
    TX_DATA   = 5'b00100,
    TX_PARITY = 5'b01000,
    TX_STOP   = 5'b10000
  } udi_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP   = 5'b10000
  } udi_rx_state_t;

  function automatic logic udi_parity(input logic [7:0] data, input logic odd);
    udi_parity = (^data) ^ odd;
  endfunction

  function automatic logic udi_hit(input logic [31:0] addr, input logic [5:0] off);
    udi_hit = (addr[31:2] == {26'h0000000, off[5:2]});
  endfunction

endpackage

// >>> design/udi_sync.sv
// two-stage synchroniser for the serial input pin
module udi_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1Reg;

  // resting line level is high, so both stages start there
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1Reg <= 1'b1;
      syncOut   <= 1'b1;
    end else if (ce) begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end
endmodule // udi_sync

// >>> design/udi_uart.sv
// serial channel with data-logic and line-polarity inversion behind an AXI4-Lite slave
module udi_uart (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         serialInputPin,
  output logic              serialOutputPin
);
  import udi_pkg::*;

  udi_mode_t     modeReg;
  udi_ctrl_t     ctrlReg;
  logic [15:0]   brgReg;
  logic [15:0]   brgCntReg;
  logic          tick;

  logic [31:0]   awAddrReg;
  logic [31:0]   wDataReg;
  logic [3:0]    wStrbReg;
  logic          awHeldReg;
  logic          wHeldReg;
  logic          doWrite;
  logic          rdTake;
  logic [31:0]   rdNext;
  logic          rdHit;

  logic [7:0]    txBufReg;
  logic          txEmptyReg;
  logic          txTake;
  logic          txBufWrite;
  udi_tx_state_t txState;
  logic [3:0]    txPhaseReg;
  logic          txEdge;
  logic [7:0]    txShiftReg;
  logic [3:0]    txCntReg;
  logic          txParReg;
  logic          txStopReg;
  logic          txNextBit;

  logic          rxSync;
  logic          rxLine;
  udi_rx_state_t rxState;
  logic [3:0]    rxPhaseReg;
  logic          rxSample;
  logic [7:0]    rxShiftReg;
  logic [3:0]    rxCntReg;
  logic          rxParErrReg;
  logic          rxStopReg;
  logic          rxDone;
  logic          rxFrmErr;
  logic [7:0]    rxBufReg;
  logic          rxFullReg;
  logic          rxOvrReg;
  logic          rxFrmReg;
  logic          rxParReg;
  logic          rxBufRead;

  // ---------------- bit-rate divider, shared by both directions
  assign tick = ce && (brgCntReg == brgReg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      brgCntReg <= 16'h0000;
    end else if (ce) begin
      brgCntReg <= tick ? 16'h0000 : brgCntReg + 16'h0001;
    end
  end

  // ---------------- AXI4-Lite write path
  assign doWrite    = awHeldReg && wHeldReg && !s_axi_bvalid;
  assign txBufWrite = doWrite && udi_hit(awAddrReg, OFF_TXBUF) && wStrbReg[0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awAddrReg     <= 32'h00000000;
      wDataReg      <= 32'h00000000;
      wStrbReg      <= 4'h0;
      awHeldReg     <= 1'b0;
      wHeldReg      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrReg     <= s_axi_awaddr;
        awHeldReg     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataReg     <= s_axi_wdata;
        wStrbReg     <= s_axi_wstrb;
        wHeldReg     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (udi_hit(awAddrReg, OFF_MODE)  || udi_hit(awAddrReg, OFF_CTRL0) ||
                         udi_hit(awAddrReg, OFF_CTRL1) || udi_hit(awAddrReg, OFF_TXBUF) ||
                         udi_hit(awAddrReg, OFF_RXBUF) || udi_hit(awAddrReg, OFF_BRG))
                        ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHeldReg     <= 1'b0;
        wHeldReg      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // configuration registers; the receive buffer and status bits ignore writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg <= '0;
      ctrlReg <= '0;
      brgReg  <= BRG_RESET;
    end else if (ce && doWrite) begin
      if (udi_hit(awAddrReg, OFF_MODE) && wStrbReg[0]) begin
        modeReg.stopBitCount <= wDataReg[MODE_STOP2];
        modeReg.parityOdd    <= wDataReg[MODE_PAR_ODD];
        modeReg.parityEnable <= wDataReg[MODE_PAR_EN];
        modeReg.lineInvert   <= wDataReg[MODE_LINE_INV];
      end
      if (udi_hit(awAddrReg, OFF_CTRL0) && wStrbReg[0]) begin
        ctrlReg.clockEdge <= wDataReg[CTRL0_EDGE];
        ctrlReg.bitOrder  <= wDataReg[CTRL0_ORDER];
      end
      if (udi_hit(awAddrReg, OFF_CTRL1) && wStrbReg[0]) begin
        ctrlReg.txEnable   <= wDataReg[CTRL1_TX_EN];
        ctrlReg.rxEnable   <= wDataReg[CTRL1_RX_EN];
        ctrlReg.dataInvert <= wDataReg[CTRL1_DATA_INV];
      end
      if (udi_hit(awAddrReg, OFF_BRG)) begin
        if (wStrbReg[0]) brgReg[7:0]  <= wDataReg[7:0];
        if (wStrbReg[1]) brgReg[15:8] <= wDataReg[15:8];
      end
    end
  end

  // ---------------- AXI4-Lite read path
  assign rdTake    = s_axi_arvalid && s_axi_arready;
  assign rxBufRead = ce && rdTake && udi_hit(s_axi_araddr, OFF_RXBUF);

  always_comb begin
    rdNext = 32'h00000000;
    rdHit  = 1'b1;
    if (udi_hit(s_axi_araddr, OFF_MODE)) begin
      rdNext[MODE_STOP2]    = modeReg.stopBitCount;
      rdNext[MODE_PAR_ODD]  = modeReg.parityOdd;
      rdNext[MODE_PAR_EN]   = modeReg.parityEnable;
      rdNext[MODE_LINE_INV] = modeReg.lineInvert;
    end else if (udi_hit(s_axi_araddr, OFF_CTRL0)) begin
      rdNext[CTRL0_EDGE]    = ctrlReg.clockEdge;
      rdNext[CTRL0_ORDER]   = ctrlReg.bitOrder;
      rdNext[CTRL0_TX_BUSY] = (txState != TX_IDLE);
    end else if (udi_hit(s_axi_araddr, OFF_CTRL1)) begin
      rdNext[CTRL1_TX_EN]    = ctrlReg.txEnable;
      rdNext[CTRL1_TX_EMPTY] = txEmptyReg;
      rdNext[CTRL1_RX_EN]    = ctrlReg.rxEnable;
      rdNext[CTRL1_RX_FULL]  = rxFullReg;
      rdNext[CTRL1_DATA_INV] = ctrlReg.dataInvert;
    end else if (udi_hit(s_axi_araddr, OFF_TXBUF)) begin
      rdNext[7:0] = txBufReg;
    end else if (udi_hit(s_axi_araddr, OFF_RXBUF)) begin
      rdNext[7:0]           = rxBufReg ^ {8{ctrlReg.dataInvert}};
      rdNext[RXBUF_OVERRUN] = rxOvrReg;
      rdNext[RXBUF_FRAMING] = rxFrmReg;
      rdNext[RXBUF_PARITY]  = rxParReg;
      rdNext[RXBUF_FULL]    = rxFullReg;
    end else if (udi_hit(s_axi_araddr, OFF_BRG)) begin
      rdNext[15:0] = brgReg;
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (rdTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdNext;
        s_axi_rresp   <= rdHit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------- transmit buffer; a write in the take cycle keeps it full
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txBufReg   <= DATA_RESET;
      txEmptyReg <= 1'b1;
    end else if (ce) begin
      if (txTake) begin
        txEmptyReg <= 1'b1;
      end
      if (txBufWrite) begin
        txBufReg   <= wDataReg[7:0];
        txEmptyReg <= 1'b0;
      end
    end
  end

  // ---------------- transmitter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txPhaseReg <= 4'h0;
    end else if (tick) begin
      txPhaseReg <= txPhaseReg + 4'h1;
    end
  end

  // the bit boundary is the falling or the rising edge of the transfer clock
  assign txEdge    = tick && (txPhaseReg == (ctrlReg.clockEdge ? PHASE_RISE : PHASE_FALL));
  assign txNextBit = ctrlReg.bitOrder ? txShiftReg[7] : txShiftReg[0];
  assign txTake    = ce && (txState == TX_IDLE) && txEdge && ctrlReg.txEnable && !txEmptyReg;

  // the pin flop holds the line level already xored with the polarity, so
  // the output needs no gate after it; idle and stop levels flip too
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txState         <= TX_IDLE;
      txShiftReg      <= DATA_RESET;
      txCntReg        <= 4'h0;
      txParReg        <= 1'b0;
      txStopReg       <= 1'b0;
      serialOutputPin <= 1'b1;
    end else if (ce) begin
      unique case (txState)
        TX_IDLE: begin
          serialOutputPin <= 1'b1 ^ modeReg.lineInvert;
          if (txTake) begin
            txShiftReg      <= txBufReg ^ {8{ctrlReg.dataInvert}};
            txParReg        <= udi_parity(txBufReg ^ {8{ctrlReg.dataInvert}}, modeReg.parityOdd);
            txCntReg        <= 4'h0;
            serialOutputPin <= 1'b0 ^ modeReg.lineInvert;
            txState         <= TX_START;
          end
        end
        TX_START: begin
          if (txEdge) begin
            serialOutputPin <= txNextBit ^ modeReg.lineInvert;
            txShiftReg      <= ctrlReg.bitOrder ? {txShiftReg[6:0], 1'b0} : {1'b0, txShiftReg[7:1]};
            txCntReg        <= 4'h1;
            txState         <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (txEdge) begin
            if (txCntReg == DATA_BITS) begin
              txStopReg <= 1'b0;
              if (modeReg.parityEnable) begin
                serialOutputPin <= txParReg ^ modeReg.lineInvert;
                txState         <= TX_PARITY;
              end else begin
                serialOutputPin <= 1'b1 ^ modeReg.lineInvert;
                txState         <= TX_STOP;
              end
            end else begin
              serialOutputPin <= txNextBit ^ modeReg.lineInvert;
              txShiftReg      <= ctrlReg.bitOrder ? {txShiftReg[6:0], 1'b0} : {1'b0, txShiftReg[7:1]};
              txCntReg        <= txCntReg + 4'h1;
            end
          end
        end
        TX_PARITY: begin
          if (txEdge) begin
            serialOutputPin <= 1'b1 ^ modeReg.lineInvert;
            txState         <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (txEdge) begin
            if (modeReg.stopBitCount && !txStopReg) begin
              txStopReg <= 1'b1;
            end else begin
              txState <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------- receiver
  udi_sync rxSyncInst (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .asyncIn (serialInputPin),
    .syncOut (rxSync)
  );

  assign rxLine   = rxSync ^ modeReg.lineInvert;
  assign rxSample = tick && (rxPhaseReg == PHASE_SAMPLE);
  assign rxDone   = ce && (rxState == RX_STOP) && rxSample && !(modeReg.stopBitCount && (rxCntReg == DATA_BITS));
  assign rxFrmErr = rxStopReg ? 1'b0 : !rxLine;

  // a bit is taken near its middle, eight ticks after the start edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxState     <= RX_IDLE;
      rxPhaseReg  <= 4'h0;
      rxShiftReg  <= DATA_RESET;
      rxCntReg    <= 4'h0;
      rxParErrReg <= 1'b0;
      rxStopReg   <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        rxPhaseReg <= rxPhaseReg + 4'h1;
      end
      unique case (rxState)
        RX_IDLE: begin
          if (ctrlReg.rxEnable && !rxLine) begin
            rxPhaseReg <= 4'h0;
            rxState    <= RX_START;
          end
        end
        RX_START: begin
          if (rxSample) begin
            rxCntReg    <= 4'h0;
            rxParErrReg <= 1'b0;
            rxStopReg   <= 1'b0;
            rxState     <= rxLine ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxSample) begin
            rxShiftReg <= ctrlReg.bitOrder ? {rxShiftReg[6:0], rxLine} : {rxLine, rxShiftReg[7:1]};
            rxCntReg   <= rxCntReg + 4'h1;
            if (rxCntReg == DATA_BITS - 4'h1) begin
              rxState <= modeReg.parityEnable ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rxSample) begin
            rxParErrReg <= rxLine != udi_parity(rxShiftReg, modeReg.parityOdd);
            rxState     <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxSample) begin
            if (modeReg.stopBitCount && (rxCntReg == DATA_BITS)) begin
              // clearing the count marks the first of two stop bits as seen
              rxStopReg <= !rxLine; // remembers a bad first stop bit
              rxCntReg  <= 4'h0;
            end else begin
              rxState <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // receive buffer keeps line data; a frame landing on a read still sets full
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxBufReg  <= DATA_RESET;
      rxFullReg <= 1'b0;
      rxOvrReg  <= 1'b0;
      rxFrmReg  <= 1'b0;
      rxParReg  <= 1'b0;
    end else if (ce) begin
      if (rxBufRead) begin
        rxFullReg <= 1'b0;
        rxOvrReg  <= 1'b0;
        rxFrmReg  <= 1'b0;
        rxParReg  <= 1'b0;
      end
      if (rxDone) begin
        rxBufReg  <= rxShiftReg;
        rxFullReg <= 1'b1;
        rxOvrReg  <= rxFullReg && !rxBufRead;
        rxFrmReg  <= rxFrmErr || (modeReg.stopBitCount && rxStopReg);
        rxParReg  <= modeReg.parityEnable && rxParErrReg;
      end
    end
  end
endmodule // udi_uart

// >>> verification/udi_uart_monitor.sv
// concurrent checks on the serial channel's bus ports and its serial output pin
module udi_uart_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serialInputPin,
  input wire logic        serialOutputPin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence wr_taken;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    ce && s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  a_unmapped_wr: assert property (wr_taken ##0 (s_axi_awaddr > 32'h00000017) |-> ##2 s_axi_bresp == 2'b11)
    else $error("unmapped write not refused");
  a_mapped_wr: assert property (wr_taken ##0 (s_axi_awaddr < 32'h00000018) |-> ##2 s_axi_bresp == 2'b00)
    else $error("mapped write refused");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_unmapped_rd: assert property (rd_taken ##0 (s_axi_araddr > 32'h00000017) |=>
    s_axi_rresp == 2'b11 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  // a bit is sixteen clocks at the fastest divider, so half of it must stand still
  a_bit_stands: assert property ($changed(serialOutputPin) |=> $stable(serialOutputPin) [*8])
    else $error("serial output bit too short");
endmodule // udi_uart_monitor

bind udi_uart udi_uart_monitor u_mon (.*);

// >>> verification/udi_peer.sv
// remote serial transceiver on the far end of the line
module udi_peer (
  input  wire logic clk,
  input  wire logic lineInv,
  input  wire logic serialOutputPin,
  output logic      serialInputPin
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CLKS = 16;
  logic driving = 1'b0;

  initial serialInputPin = 1'b1;
  // an idle line rests at the mark level, low once polarity is turned round
  always @(posedge clk) begin
    if (!driving) serialInputPin <= ~lineInv;
  end

  task automatic send(input logic [7:0] v);
    logic [10:0] f;
    f = {1'b1, ^v, v, 1'b0} ^ {11{lineInv}};
    driving = 1'b1;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      serialInputPin <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    driving = 1'b0;
  endtask

  // samples mid-bit and returns in the middle of the last bit, so a frame
  // that follows at once, or after an idle gap, is still caught at its start
  task automatic grab(input int n, output logic [21:0] bits);
    bits = '0;
    wait (serialOutputPin === lineInv);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      if (i != 0) repeat (BIT_CLKS) @(posedge clk);
      bits[i] = serialOutputPin;
    end
  endtask
endmodule // udi_peer

// >>> verification/tb.sv
// self-checking bench for the serial channel's data and line inversion
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import udi_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce = 1'b1;
  logic [31:0] s_axi_awaddr = '0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = '0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        serialInputPin;
  logic        serialOutputPin;
  logic        lineInv = 1'b0;
  int          mismatches = 0;
  int          n_compared = 0;

  always #4 clk = ~clk;
  udi_uart u_dut (.*);
  udi_peer u_peer (.*);

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int t = 0; t < 50; t++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int t = 0; t < 50; t++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] off, input logic [31:0] d);
    logic [1:0] r;
    axi_wr({26'h0, off}, d, r);
    cmp({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask

  task automatic poll(input logic [5:0] off, input int b);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 200; i++) begin
      axi_rd({26'h0, off}, d, r);
      if (d[b] === 1'b1) break;
    end
    cmp({31'h0, d[b]}, 32'h1, "status flag");
  endtask

  function automatic logic [10:0] frame(input logic [7:0] v, input logic li);
    return {1'b1, ^v, v, 1'b0} ^ {11{li}};
  endfunction

  // receiver stays off while the polarity flips, else it would see a false start
  task automatic setup(input logic di, input logic li);
    wr(OFF_CTRL1, 32'h0);
    wr(OFF_MODE, {28'h0, li, 3'b100});
    lineInv <= li;
    repeat (20) @(posedge clk);
    wr(OFF_CTRL1, {27'h0, di, 4'h5});
  endtask

  task automatic test_regs();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFF_MODE, 32'h0000000C);
    axi_rd({26'h0, OFF_MODE}, d, r);
    cmp({28'h0, d[3:0]}, 32'hC, "mode readback");
    wr(OFF_CTRL1, 32'h00000010);
    axi_rd({26'h0, OFF_CTRL1}, d, r);
    cmp({31'h0, d[4]}, 32'h1, "data invert readback");
    axi_rd({26'h0, OFF_CTRL0}, d, r);
    cmp({30'h0, d[1:0]}, 32'h0, "edge and order reset");
    axi_wr(32'h00000020, 32'hFFFFFFFF, r);
    cmp({30'h0, r}, {30'h0, RESP_DECERR}, "unmapped write");
    axi_rd(32'h00000020, d, r);
    cmp({30'h0, r}, {30'h0, RESP_DECERR}, "unmapped read");
    cmp(d, 32'h0, "unmapped read data");
    wr(OFF_MODE, 32'h0);
    wr(OFF_CTRL1, 32'h0);
    $display("test_regs done");
  endtask

  task automatic test_tx(input logic di, input logic li);
    logic [21:0] got;
    logic [21:0] got2;
    logic [7:0] m;
    setup(di, li);
    m = {8{di}};
    fork
      begin
        u_peer.grab(11, got);
        u_peer.grab(11, got2);
      end
      begin
        wr(OFF_TXBUF, 32'h000000A4);
        poll(OFF_CTRL1, CTRL1_TX_EMPTY);
        wr(OFF_TXBUF, 32'h0000003C);
      end
    join
    cmp({21'h0, got[10:0]}, {21'h0, frame(8'hA4 ^ m, li)}, "tx first frame");
    cmp({21'h0, got2[10:0]}, {21'h0, frame(8'h3C ^ m, li)}, "tx second frame");
    repeat (16) @(posedge clk);
    $display("test_tx done dinv=%0b linv=%0b", di, li);
  endtask

  task automatic test_rx(input logic di, input logic li);
    logic [31:0] d;
    logic [1:0] r;
    setup(di, li);
    u_peer.send(8'h97);
    poll(OFF_CTRL1, CTRL1_RX_FULL);
    axi_rd({26'h0, OFF_RXBUF}, d, r);
    cmp({20'h0, d[15:12], d[7:0]}, {20'h0, 4'h8, 8'h97 ^ {8{di}}}, "rx word");
    wr(OFF_CTRL1, {27'h0, ~di, 4'h5});
    axi_rd({26'h0, OFF_RXBUF}, d, r);
    cmp({24'h0, d[7:0]}, {24'h0, 8'h97 ^ {8{~di}}}, "rx reread");
    $display("test_rx done dinv=%0b linv=%0b", di, li);
  endtask

  // most significant bit first, no parity, two stop bits
  task automatic test_fmt();
    logic [21:0] got;
    setup(1'b0, 1'b0);
    wr(OFF_MODE, 32'h00000001);
    wr(OFF_CTRL0, 32'h00000002);
    fork
      u_peer.grab(11, got);
      wr(OFF_TXBUF, 32'h000000A4);
    join
    cmp({21'h0, got[10:0]}, {21'h0, 11'h64A}, "msb first, two stops");
    $display("test_fmt done");
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    test_regs();
    for (int k = 0; k < 4; k++) begin
      test_tx(k[0], k[1]);
      test_rx(k[0], k[1]);
    end
    test_fmt();
    give_verdict();
  end

  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule // tb
